// *** inc/rsf_defines.svh ***
// offsets, field positions, reset values and timing counts of the reset-source block
`ifndef RSF_DEFINES_SVH
`define RSF_DEFINES_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define RSF_OFS_THRESH     8'h00
`define RSF_OFS_CAUSE      8'h04
`define RSF_OFS_STATUS     8'h08
`define RSF_OFS_FLASH1     8'h0C
`define RSF_OFS_IRQ_STAT   8'h10
`define RSF_OFS_IRQ_MASK   8'h14

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define RSF_CAUSE_WDCF     0
`define RSF_CAUSE_SCF      1
`define RSF_CAUSE_LVF      2
`define RSF_STAT_PDF       0
`define RSF_STAT_TO        1
`define RSF_THR_RO_MASK    8'h0C

// ----------------------------------------------------------------------------
// threshold select codes and reset values
// ----------------------------------------------------------------------------
`define RSF_THR_1V70       8'h66
`define RSF_THR_1V90       8'h55
`define RSF_THR_2V55       8'h33
`define RSF_THR_3V15       8'h99
`define RSF_THR_3V80       8'hAA
`define RSF_THR_OFF        8'hF0
`define RSF_THR_POR        8'h66
`define RSF_FLASH1_MAGIC   8'h55
`define RSF_IRQ_W          5

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define RSF_CLK_MHZ        10
`define RSF_T_LVQ_NS       1000
`define RSF_LVQ_CYC        ((`RSF_T_LVQ_NS * `RSF_CLK_MHZ + 999) / 1000)
`define RSF_RST_DLY_CYC    1
`define RSF_RST_HOLD_CYC   4

`endif

// *** inc/rsf_pkg.sv ***
// types shared by the reset-source block
package rsf_pkg;

   // ----------------------------------------------------------------------------
   // sequencer states, one-hot
   // ----------------------------------------------------------------------------
   typedef enum logic [2:0] {
      RSF_IDLE = 3'b001,
      RSF_WAIT = 3'b010,
      RSF_HOLD = 3'b100
   } rsf_state_e;

   // ----------------------------------------------------------------------------
   // cause of the last full device reset
   // ----------------------------------------------------------------------------
   typedef struct packed {
      logic in_application_programming;
      logic wdt_ctrl;
      logic wdt_tmo;
      logic code_fault;
      logic lowv;
   } rsf_cause_s;

endpackage : rsf_pkg

// *** hw/rsf_top.sv ***
// reset-source, reset-cause flag and threshold-select logic with wishbone slave
//
// Implementation choices: the register offsets and register access over Wishbone.
`timescale 1ns/1ns
`include "rsf_defines.svh"

module rsf_top
   import rsf_pkg::*;
(
   input  wire logic        clk_i,             // sub clock, 10 MHz
   input  wire logic        rstn_i,            // power-on reset, active low
   input  wire logic        wb_cyc_i,          // wishbone cycle
   input  wire logic        wb_stb_i,          // wishbone strobe
   input  wire logic        wb_we_i,           // wishbone write enable
   input  wire logic [7:0]  wb_adr_i,          // wishbone byte address
   input  wire logic [3:0]  wb_sel_i,          // wishbone byte selects
   input  wire logic [31:0] wb_dat_i,          // wishbone write data
   output logic      [31:0] wb_dat_o,          // wishbone read data
   output logic             wb_ack_o,          // wishbone acknowledge
   input  wire logic        lowv_i,            // supply comparator: below threshold
   input  wire logic        sleep_idle_i,      // core is in sleep or idle
   input  wire logic        halt_i,            // pulse: halt instruction executed
   input  wire logic        wdt_timeout_i,     // pulse: watchdog overflow
   input  wire logic        wdt_ctrl_fault_i,  // pulse: bad watchdog control value
   output logic             dev_reset_o,       // full device reset
   output logic             pc_sp_clear_o,     // pulse: clear PC and stack pointer only
   output logic             wdt_clear_o,       // clear watchdog and time bases
   output logic             lvr_active_o,      // low-voltage monitor armed
   output logic [2:0]       vsel_o,            // comparator threshold index
   output rsf_cause_s       cause_o,           // cause of last full reset
   output logic             irq_o              // level interrupt
);

   // ----------------------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------------------
   logic [1:0] rst_sync_reg;
   logic       rst_n;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_sync_reg <= 2'b00;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end

   assign rst_n = rst_sync_reg[1];

   // ----------------------------------------------------------------------------
   // wishbone slave
   // ----------------------------------------------------------------------------
   logic       req;
   logic       ack_reg;
   logic       wr;
   logic [7:0] wbyte;

   assign req   = wb_cyc_i & wb_stb_i;
   assign wr    = req & wb_we_i & ack_reg & wb_sel_i[0];
   assign wbyte = wb_dat_i[7:0];

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= req & ~ack_reg;
      end
   end

   assign wb_ack_o = ack_reg;

   // ----------------------------------------------------------------------------
   // threshold select decode
   // ----------------------------------------------------------------------------
   logic [7:0] thr_reg;
   logic [7:0] thr_next;
   logic       code_known;
   logic       code_off;
   logic [2:0] vsel;

   always_comb begin
      code_known = 1'b1;
      code_off   = 1'b0;
      vsel       = 3'h0;
      case (thr_reg)
         `RSF_THR_1V70: vsel = 3'h0;
         `RSF_THR_1V90: vsel = 3'h1;
         `RSF_THR_2V55: vsel = 3'h2;
         `RSF_THR_3V15: vsel = 3'h3;
         `RSF_THR_3V80: vsel = 3'h4;
         `RSF_THR_OFF:  code_off = 1'b1;
         default:       code_known = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------------------
   // low-voltage qualification
   // ----------------------------------------------------------------------------
   logic [7:0] lvq_cnt_reg;
   logic       lvr_arm;
   logic       lowv_qual;
   logic       busy;

   assign lvr_arm = ~sleep_idle_i & code_known & ~code_off;

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         lvq_cnt_reg <= 8'h00;
      end else if (!lvr_arm || !lowv_i || busy) begin
         lvq_cnt_reg <= 8'h00;
      end else if (lvq_cnt_reg <= 8'(`RSF_LVQ_CYC)) begin
         lvq_cnt_reg <= lvq_cnt_reg + 8'h01;
      end
   end

   // longer than the qualify time: one count past it
   assign lowv_qual = (lvq_cnt_reg > 8'(`RSF_LVQ_CYC));

   // ----------------------------------------------------------------------------
   // registered event detection
   // ----------------------------------------------------------------------------
   logic fault_det_reg;
   logic lowv_det_reg;
   logic iap_det_reg;
   logic iap_wr;

   assign iap_wr = wr & (wb_adr_i == `RSF_OFS_FLASH1) & (wbyte == `RSF_FLASH1_MAGIC);

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         fault_det_reg <= 1'b0;
         lowv_det_reg  <= 1'b0;
         iap_det_reg   <= 1'b0;
      end else begin
         fault_det_reg <= ~code_known & ~busy;
         lowv_det_reg  <= lowv_qual & ~busy;
         iap_det_reg   <= iap_wr & ~busy;
      end
   end

   // ----------------------------------------------------------------------------
   // reset sequencer
   // ----------------------------------------------------------------------------
   rsf_state_e state_reg;
   rsf_cause_s cause_reg;
   rsf_cause_s ev;
   logic [2:0] cnt_reg;
   logic       start;
   logic       wdt_run_tmo;
   logic       wdt_sleep_tmo;

   assign wdt_run_tmo   = wdt_timeout_i & ~sleep_idle_i;
   assign wdt_sleep_tmo = wdt_timeout_i & sleep_idle_i;

   always_comb begin
      ev            = '0;
      ev.lowv       = lowv_det_reg;
      ev.code_fault = fault_det_reg;
      ev.wdt_tmo    = wdt_run_tmo;
      ev.wdt_ctrl   = wdt_ctrl_fault_i;
      ev.in_application_programming        = iap_det_reg;
   end

   assign start = (state_reg == RSF_IDLE) & (|ev);
   assign busy  = (state_reg != RSF_IDLE);

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= RSF_IDLE;
         cnt_reg   <= 3'h0;
      end else begin
         case (state_reg)
            RSF_IDLE: begin
               cnt_reg <= 3'h0;
               if (|ev) begin
                  state_reg <= RSF_WAIT;
               end
            end
            RSF_WAIT: begin
               // reset lands 2..3 cycles after the condition is seen
               if (cnt_reg == 3'(`RSF_RST_DLY_CYC - 1)) begin
                  state_reg <= RSF_HOLD;
                  cnt_reg   <= 3'h0;
               end else begin
                  cnt_reg <= cnt_reg + 3'h1;
               end
            end
            RSF_HOLD: begin
               if (cnt_reg == 3'(`RSF_RST_HOLD_CYC - 1)) begin
                  state_reg <= RSF_IDLE;
                  cnt_reg   <= 3'h0;
               end else begin
                  cnt_reg <= cnt_reg + 3'h1;
               end
            end
            default: begin
               state_reg <= RSF_IDLE;
               cnt_reg   <= 3'h0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         cause_reg <= '0;
      end else if (start) begin
         cause_reg <= ev;
      end
   end

   // ----------------------------------------------------------------------------
   // reset outputs
   // ----------------------------------------------------------------------------
   logic pcsp_reg;

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         pcsp_reg <= 1'b0;
      end else begin
         pcsp_reg <= wdt_sleep_tmo;
      end
   end

   // core holds PC at zero, irqs off, timers off, ports in, SP top
   assign dev_reset_o   = ~rst_n | (state_reg == RSF_HOLD);
   assign pc_sp_clear_o = pcsp_reg;
   assign wdt_clear_o   = dev_reset_o | pcsp_reg;
   assign lvr_active_o  = lvr_arm;
   assign cause_o       = cause_reg;

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         vsel_o <= 3'h0;
      end else begin
         vsel_o <= vsel;
      end
   end

   // ----------------------------------------------------------------------------
   // threshold select register
   // ----------------------------------------------------------------------------
   always_comb begin
      thr_next = thr_reg;
      if (wr && (wb_adr_i == `RSF_OFS_THRESH)) begin
         thr_next = (wbyte & ~`RSF_THR_RO_MASK) | (thr_reg & `RSF_THR_RO_MASK);
      end
      // besides power-on reset only a select fault restores it; a low-voltage reset keeps it
      if (start && ev.code_fault) begin
         thr_next = `RSF_THR_POR;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         thr_reg <= `RSF_THR_POR;
      end else begin
         thr_reg <= thr_next;
      end
   end

   // ----------------------------------------------------------------------------
   // sticky reset-cause flags
   // ----------------------------------------------------------------------------
   logic [2:0] flag_reg;
   logic [2:0] flag_set;
   logic [2:0] flag_clr;

   always_comb begin
      flag_set = 3'h0;
      flag_set[`RSF_CAUSE_LVF]  = start & ev.lowv;
      flag_set[`RSF_CAUSE_SCF]  = start & ev.code_fault;
      flag_set[`RSF_CAUSE_WDCF] = wdt_ctrl_fault_i;
      flag_clr = 3'h0;
      if (wr && (wb_adr_i == `RSF_OFS_CAUSE)) begin
         flag_clr = ~wbyte[2:0];
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         flag_reg <= 3'h0;
      end else begin
         flag_reg <= (flag_reg & ~flag_clr) | flag_set;
      end
   end

   // ----------------------------------------------------------------------------
   // timeout and power-down status
   // ----------------------------------------------------------------------------
   logic to_reg;
   logic pdf_reg;

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         to_reg  <= 1'b0;
         pdf_reg <= 1'b0;
      end else if (wdt_sleep_tmo) begin
         to_reg  <= 1'b1;
         pdf_reg <= 1'b1;
      end else if (wdt_run_tmo) begin
         to_reg  <= 1'b1;
      end else if (halt_i) begin
         to_reg  <= 1'b0;
         pdf_reg <= 1'b1;
      end
   end

   // ----------------------------------------------------------------------------
   // interrupt status and mask
   // ----------------------------------------------------------------------------
   logic [`RSF_IRQ_W-1:0] irq_stat_reg;
   logic [`RSF_IRQ_W-1:0] irq_mask_reg;
   logic [`RSF_IRQ_W-1:0] irq_ev;
   logic [`RSF_IRQ_W-1:0] irq_clr;

   always_comb begin
      irq_ev  = ev & {`RSF_IRQ_W{~busy}};
      irq_ev[2] = wdt_timeout_i;
      irq_clr = '0;
      if (wr && (wb_adr_i == `RSF_OFS_IRQ_STAT)) begin
         irq_clr = wbyte[`RSF_IRQ_W-1:0];
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat_reg <= '0;
      end else begin
         irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_ev;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         irq_mask_reg <= '0;
      end else if (wr && (wb_adr_i == `RSF_OFS_IRQ_MASK)) begin
         irq_mask_reg <= wbyte[`RSF_IRQ_W-1:0];
      end
   end

   assign irq_o = |(irq_stat_reg & irq_mask_reg);

   // ----------------------------------------------------------------------------
   // read data
   // ----------------------------------------------------------------------------
   logic [7:0] rbyte;

   always_comb begin
      case (wb_adr_i)
         `RSF_OFS_THRESH:   rbyte = thr_reg;
         `RSF_OFS_CAUSE:    rbyte = {5'h00, flag_reg};
         `RSF_OFS_STATUS:   rbyte = {6'h00, to_reg, pdf_reg};
         `RSF_OFS_IRQ_STAT: rbyte = {3'h0, irq_stat_reg};
         `RSF_OFS_IRQ_MASK: rbyte = {3'h0, irq_mask_reg};
         default:           rbyte = 8'h00;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (req && !ack_reg) begin
         wb_dat_o <= {24'h00_0000, rbyte};
      end
   end

endmodule : rsf_top

// *** verif/rsf_top_monitor.sv ***
// assertion checker on the ports of the reset-source block
`timescale 1ns/1ns
`include "rsf_defines.svh"
module rsf_top_monitor (
   input wire logic        clk_i,         // sub clock
   input wire logic        rstn_i,        // power-on reset
   input wire logic        wb_cyc_i,      // cycle
   input wire logic        wb_stb_i,      // strobe
   input wire logic        wb_we_i,       // write enable
   input wire logic [7:0]  wb_adr_i,      // address
   input wire logic [3:0]  wb_sel_i,      // byte selects
   input wire logic [31:0] wb_dat_i,      // write data
   input wire logic [31:0] wb_dat_o,      // read data
   input wire logic        wb_ack_o,      // acknowledge
   input wire logic        sleep_idle_i,  // core asleep
   input wire logic        wdt_timeout_i, // watchdog overflow
   input wire logic        dev_reset_o,   // device reset
   input wire logic        pc_sp_clear_o, // partial clear
   input wire logic        wdt_clear_o,   // watchdog clear
   input wire logic        lvr_active_o   // monitor armed
);
   logic       wr_ack;
   logic [7:0] eff;
   assign wr_ack = wb_ack_o && wb_we_i && wb_sel_i[0] && !dev_reset_o;
   // bits 3:2 are read-only and always hold 01
   assign eff = {wb_dat_i[7:4], 2'b01, wb_dat_i[1:0]};
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rstn_i);
   sequence s_hold;
      dev_reset_o [*4] ##1 !dev_reset_o;
   endsequence
   sequence s_part;
      pc_sp_clear_o ##1 !pc_sp_clear_o;
   endsequence
   ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("no ack in the cycle after a request");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   cause_read_a: assert property (
      wb_ack_o && !wb_we_i && wb_adr_i == `RSF_OFS_CAUSE |-> wb_dat_o[31:3] == 29'h0)
      else $error("upper cause bits not zero");
   hold_len_a: assert property ($rose(dev_reset_o) |-> s_hold)
      else $error("device reset not held four cycles");
   code_rst_a: assert property (
      wr_ack && wb_adr_i == `RSF_OFS_THRESH && !(eff inside {`RSF_THR_1V70, `RSF_THR_1V90})
      |-> ##[2:5] dev_reset_o) else $error("undefined code gave no reset");
   flash_rst_a: assert property (
      wr_ack && wb_adr_i == `RSF_OFS_FLASH1 && wb_dat_i[7:0] == `RSF_FLASH1_MAGIC
      |-> ##[2:5] dev_reset_o) else $error("flash magic gave no reset");
   wdt_run_a: assert property (
      wdt_timeout_i && !sleep_idle_i && !dev_reset_o |-> ##[1:5] dev_reset_o)
      else $error("running timeout gave no reset");
   wdt_sleep_a: assert property (
      wdt_timeout_i && sleep_idle_i && !dev_reset_o |=> s_part)
      else $error("sleeping timeout gave no partial clear");
   sleep_off_a: assert property (sleep_idle_i |-> !lvr_active_o)
      else $error("monitor armed in sleep");
   wdt_clr_a: assert property (dev_reset_o || pc_sp_clear_o |-> wdt_clear_o)
      else $error("watchdog not cleared on reset");
endmodule : rsf_top_monitor

bind rsf_top rsf_top_monitor u_mon (
   .clk_i(clk_i), .rstn_i(rstn_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sleep_idle_i(sleep_idle_i),
   .wdt_timeout_i(wdt_timeout_i), .dev_reset_o(dev_reset_o), .pc_sp_clear_o(pc_sp_clear_o),
   .wdt_clear_o(wdt_clear_o), .lvr_active_o(lvr_active_o)
);

// *** verif/rsf_supply_model.sv ***
// supply comparator model: flags supply below the selected threshold
`timescale 1ns/1ns
module rsf_supply_model (
   input  wire logic [11:0] supply_mv_i, // supply level in mV
   input  wire logic [2:0]  vsel_i,      // threshold index
   output logic             lowv_o       // below threshold
);
   logic [11:0] thr;
   always_comb begin
      case (vsel_i)
         3'h0: thr = 12'h6A4;
         3'h1: thr = 12'h76C;
         3'h2: thr = 12'h9F6;
         3'h3: thr = 12'hC4E;
         3'h4: thr = 12'hED8;
         default: thr = 12'h000;
      endcase
   end
   assign lowv_o = supply_mv_i < thr;
endmodule : rsf_supply_model

// *** verif/testbench.sv ***
// self-checking bench for the reset-source block
`timescale 1ns/1ns
`include "rsf_defines.svh"
module testbench;
   logic                clk, rstn, cyc, stb, we, lowv, sleep, halt, tmo, wfault, ack;
   logic                dev_rst, psc, wclr, active, irq;
   logic [7:0]          adr, code;
   logic [3:0]          sel;
   logic [31:0]         dw, rdat, q, r;
   logic [2:0]          vsel;
   logic [11:0]         supply;
   rsf_pkg::rsf_cause_s cause;
   int                  err_total, comparisons, n, h, seed;
   int                  cyc_cnt = 0;

   rsf_top u_dut (
      .clk_i(clk), .rstn_i(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(rdat), .wb_ack_o(ack),
      .lowv_i(lowv), .sleep_idle_i(sleep), .halt_i(halt), .wdt_timeout_i(tmo),
      .wdt_ctrl_fault_i(wfault), .dev_reset_o(dev_rst), .pc_sp_clear_o(psc),
      .wdt_clear_o(wclr), .lvr_active_o(active), .vsel_o(vsel), .cause_o(cause), .irq_o(irq)
   );
   rsf_supply_model u_sup (.supply_mv_i(supply), .vsel_i(vsel), .lowv_o(lowv));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 5000) begin
         err_total++;
         conclude();
      end
   end

   task automatic conclude();
      if (err_total == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : conclude
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int k;
      k = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dw <= {24'h0, d};
      do begin
         @(posedge clk);
         k++;
      end while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
      check(k, 2);
   endtask : wb
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 8'h00);
      check(q, e);
   endtask : rd
   // edges until reset rises, then edges it stays high
   task automatic rseq(input int lim);
      n = 0;
      h = 0;
      while (dev_rst !== 1'b1 && n < lim) begin
         @(posedge clk);
         n++;
      end
      while (dev_rst === 1'b1 && h < 12) begin
         @(posedge clk);
         h++;
      end
   endtask : rseq
   task automatic quiet(input int k);
      h = 0;
      repeat (k) begin
         @(posedge clk);
         if (dev_rst !== 1'b0) h++;
      end
   endtask : quiet
   task automatic por();
      rstn <= 1'b0;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
   endtask : por

   initial begin
      seed = 32'hE7F4;
      {rstn, cyc, stb, we, sleep, halt, tmo, wfault} = 8'h00;
      adr = 8'h00;
      sel = 4'h1;
      dw = 32'h0;
      supply = 12'hCE4;
      por();
      rd(`RSF_OFS_THRESH, 32'h66);
      rd(`RSF_OFS_CAUSE, 32'h0);
      rd(`RSF_OFS_STATUS, 32'h0);
      rd(8'h1C, 32'h0);
      check(vsel, 3'h0);
      check(active, 1'b1);
      halt <= 1'b1;
      @(posedge clk);
      halt <= 1'b0;
      tmo <= 1'b1;
      @(posedge clk);
      tmo <= 1'b0;
      rseq(8);
      check(h, 4);
      check(cause, 5'h04);
      rd(`RSF_OFS_STATUS, 32'h3);
      por();
      rd(`RSF_OFS_STATUS, 32'h0);
      sleep <= 1'b1;
      supply <= 12'h400;
      tmo <= 1'b1;
      @(posedge clk);
      tmo <= 1'b0;
      @(posedge clk);
      check(psc, 1'b1);
      check(wclr, 1'b1);
      quiet(20);
      check(h, 0);
      check(active, 1'b0);
      rd(`RSF_OFS_STATUS, 32'h3);
      supply <= 12'hCE4;
      sleep <= 1'b0;
      wb(1'b1, `RSF_OFS_THRESH, 8'h55);
      rd(`RSF_OFS_THRESH, 32'h55);
      check(vsel, 3'h1);
      r = $random(seed);
      supply <= 12'h400 + {3'h0, r[8:0]};
      repeat (1 + int'(r[11:9])) @(posedge clk);
      supply <= 12'hCE4;
      quiet(20);
      check(h, 0);
      supply <= 12'h400;
      rseq(30);
      supply <= 12'hCE4;
      check(h, 4);
      check(n > `RSF_LVQ_CYC + 3 && n <= `RSF_LVQ_CYC + 5, 1'b1);
      check(cause, 5'h01);
      rd(`RSF_OFS_CAUSE, 32'h4);
      rd(`RSF_OFS_THRESH, 32'h55);
      for (int i = 0; i < 4; i++) begin
         r = $random(seed);
         code = (i == 0) ? 8'h37 : {r[7:4], 2'b01, r[1:0]};
         if (code == 8'h66 || code == 8'h55) code = code ^ 8'h80;
         wb(1'b1, `RSF_OFS_THRESH, code);
         rseq(8);
         check(n >= 2 && n <= 3, 1'b1);
         check(h, 4);
         check(cause, 5'h02);
         rd(`RSF_OFS_THRESH, 32'h66);
      end
      rd(`RSF_OFS_CAUSE, 32'h6);
      wb(1'b1, `RSF_OFS_CAUSE, 8'hFF);
      rd(`RSF_OFS_CAUSE, 32'h6);
      wb(1'b1, `RSF_OFS_CAUSE, 8'h00);
      rd(`RSF_OFS_CAUSE, 32'h0);
      wb(1'b1, `RSF_OFS_FLASH1, 8'h54);
      quiet(8);
      check(h, 0);
      wb(1'b1, `RSF_OFS_FLASH1, `RSF_FLASH1_MAGIC);
      rseq(8);
      check(h, 4);
      check(cause, 5'h10);
      rd(`RSF_OFS_FLASH1, 32'h0);
      wfault <= 1'b1;
      @(posedge clk);
      wfault <= 1'b0;
      rseq(8);
      check(cause, 5'h08);
      rd(`RSF_OFS_CAUSE, 32'h1);
      rd(`RSF_OFS_IRQ_STAT, 32'h1F);
      check(irq, 1'b0);
      wb(1'b1, `RSF_OFS_IRQ_MASK, 8'h02);
      @(posedge clk);
      check(irq, 1'b1);
      wb(1'b1, `RSF_OFS_IRQ_STAT, 8'h02);
      @(posedge clk);
      check(irq, 1'b0);
      rd(`RSF_OFS_IRQ_STAT, 32'h1D);
      rd(`RSF_OFS_IRQ_MASK, 32'h2);
      conclude();
   end
endmodule : testbench
